/* pbuf_device.sv */
/*
 * Device end: register file, 256-byte packet buffer and operating mode
 * sequencer behind a mode-0 serial slave, address byte then data byte.
 * Assumes the radio datapath is modelled by the rx_* and tx_* user ports.
 */
// Chosen here: register access over Wishbone.
// How it works
// - Registers readable always, writes expected in sleep/standby
// - 256-byte buffer, only in spread modem mode
// - Buffer readable outside sleep, holds last reception
// - Sleep erases buffer and blocks access
// - Reset receive base 0x00, transmit base 0x80
// - Both bases independently writable anywhere
// - Contents kept across modes outside sleep, except on entry into receive
// - Data port uses access pointer, then increments
// - Byte count set from received header length
// - Register holds start of last packet
// - Payload bytes stored even on integrity failure
// - Oversized receive overwrites the transmit region
// - New entry into receive discards stale content
// - Sleep allows config only; modem switch only sleep
// - Transmit sends, raises done flag, returns standby
// - Continuous receive runs until mode rewritten
// - Single receive ends after one packet, standby
// - Any mode reachable from any by write
// - Host fills transmit data in standby only; the code accepts data port writes in any mode but sleep
// - Frequency error as signed 20-bit over three registers
// - Host writes signed 8-bit rate offset
// - Carrier set by 24-bit frequency word
`timescale 1ns/100ps
module pbuf_device
   import pbuf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   pbuf_link_if.device link,
   input wire logic rx_byte_valid,
   input wire logic [pbuf_pkg::DATA_W-1:0] rx_byte,
   input wire logic rx_header_valid,
   input wire logic [pbuf_pkg::DATA_W-1:0] rx_header_len,
   input wire logic rx_packet_end,
   input wire logic rx_crc_error,
   input wire logic [19:0] freq_error_in,
   input wire logic tx_byte_ready,
   output logic tx_byte_valid,
   output logic [pbuf_pkg::DATA_W-1:0] tx_byte,
   output logic [2:0] active_mode,
   output logic [23:0] carrier_frequency_word,
   output logic [7:0] rate_offset_correction,
   output logic rx_crc_error_seen
);
   import pbuf_pkg::*;
   typedef struct packed {
      logic sck_d;
      logic [4:0] bits;
      logic [15:0] sh;
      logic [7:0] tx_sh;
      logic miso;
      logic spread;
      logic [2:0] mode;
      logic [23:0] freq;
      logic [7:0] rate_off;
      logic [19:0] fei;
      logic [7:0] tx_base;
      logic [7:0] rx_base;
      logic [7:0] ptr;
      logic [7:0] rx_wr;
      logic [7:0] rx_count;
      logic [7:0] last_start;
      logic [7:0] payload;
      logic [7:0] irq;
      logic [7:0] tx_rd;
      logic [7:0] tx_left;
      logic tx_valid;
      logic [7:0] tx_data;
      logic crc_seen;
   } dst_t;
   dst_t q, d;
   logic [7:0] mem_q [BUF_DEPTH];
   logic [7:0] mem_d [BUF_DEPTH];
   logic sck_s, sel_s, mosi_s;
   logic frame_done, is_wr;
   logic [6:0] addr;
   logic [7:0] wdata, rdata;
   logic buf_open;

   pbuf_sync u_sck (.clk(clk), .rst_n(rst_n), .din(link.sck),
      .dout(sck_s));
   // Select is synchronised active high, so the reset level of the flops
   // is the idle level and no frame seems to begin just after reset.
   pbuf_sync u_cs (.clk(clk), .rst_n(rst_n), .din(!link.cs_n),
      .dout(sel_s));
   pbuf_sync u_mosi (.clk(clk), .rst_n(rst_n), .din(link.mosi),
      .dout(mosi_s));

   // Buffer only reachable in spread modem mode and out of sleep.
   assign buf_open = q.spread && (q.mode != MODE_SLEEP);
   // The address sits low after the first byte and one place down from the
   // top when the last bit of the frame arrives.
   assign addr = (q.bits == 5'h08) ? q.sh[6:0] : q.sh[13:7];
   assign is_wr = q.sh[14];

   always_comb begin
      rdata = 8'h00;
      case (addr)
         ADDR_DATA_PORT: rdata = buf_open ? mem_q[q.ptr] : 8'h00;
         ADDR_OP_MODE: rdata = {q.spread, 4'h0, q.mode};
         ADDR_FREQ_HI: rdata = q.freq[23:16];
         ADDR_FREQ_MID: rdata = q.freq[15:8];
         ADDR_FREQ_LO: rdata = q.freq[7:0];
         ADDR_ACCESS_PTR: rdata = q.ptr;
         ADDR_TX_BASE: rdata = q.tx_base;
         ADDR_RX_BASE: rdata = q.rx_base;
         ADDR_LAST_START: rdata = q.last_start;
         ADDR_IRQ_FLAGS: rdata = q.irq;
         ADDR_RX_COUNT: rdata = q.rx_count;
         ADDR_PAYLOAD_SIZE: rdata = q.payload;
         ADDR_RATE_OFFSET: rdata = q.rate_off;
         ADDR_FEI_HI: rdata = {4'h0, q.fei[19:16]};
         ADDR_FEI_MID: rdata = q.fei[15:8];
         ADDR_FEI_LO: rdata = q.fei[7:0];
         default: rdata = 8'h00;
      endcase
   end

   always_comb begin
      d = q;
      mem_d = mem_q;
      frame_done = 1'b0;
      wdata = {q.sh[6:0], mosi_s};
      d.sck_d = sck_s;
      if (!sel_s) begin
         d.bits = 5'h00;
      end else if (sck_s && !q.sck_d) begin
         d.sh = {q.sh[14:0], mosi_s};
         d.bits = q.bits + 5'h01;
         frame_done = (q.bits == FRAME_BITS_5 - 5'h01);
      end else if (!sck_s && q.sck_d) begin
         // Falling edges shift out read data for the second byte; the one
         // after the address byte loads it, so its first bit leads.
         if (q.bits == 5'h08) begin
            d.miso = rdata[7];
            d.tx_sh = {rdata[6:0], 1'b0};
         end else begin
            d.miso = q.tx_sh[7];
            d.tx_sh = {q.tx_sh[6:0], 1'b0};
         end
      end
      if (frame_done && !is_wr && addr == ADDR_DATA_PORT && buf_open) begin
         d.ptr = q.ptr + 8'h01;
      end
      // Hardware events from the radio datapath.
      if (q.mode == MODE_RX_CONT || q.mode == MODE_RX_SINGLE) begin
         d.fei = freq_error_in;
         if (rx_header_valid) begin
            d.rx_count = rx_header_len;
            d.last_start = q.rx_wr;
         end
         if (rx_byte_valid) begin
            mem_d[q.rx_wr] = rx_byte;
            d.rx_wr = q.rx_wr + 8'h01;
         end
         if (rx_crc_error) begin
            d.crc_seen = 1'b1;
         end
         if (rx_packet_end) begin
            d.irq[IRQ_RX_DONE_BIT] = 1'b1;
            if (q.mode == MODE_RX_SINGLE) begin
               d.mode = MODE_STANDBY;
            end
         end
      end
      // continuous receive only leaves on a host mode write.
      d.tx_valid = 1'b0;
      if (q.mode == MODE_TRANSMIT && tx_byte_ready && !q.tx_valid) begin
         if (q.tx_left == 8'h00) begin
            d.irq[IRQ_TX_DONE_BIT] = 1'b1;
            d.mode = MODE_STANDBY;
         end else begin
            d.tx_valid = 1'b1;
            d.tx_data = mem_q[q.tx_rd];
            d.tx_rd = q.tx_rd + 8'h01;
            d.tx_left = q.tx_left - 8'h01;
         end
      end
      if (frame_done && is_wr) begin
         case (addr)
            ADDR_DATA_PORT: begin
               if (buf_open) begin
                  mem_d[q.ptr] = wdata;
                  d.ptr = q.ptr + 8'h01;
               end
            end
            ADDR_OP_MODE: begin
               // Modem switch only honoured from sleep.
               if (q.mode == MODE_SLEEP) begin
                  d.spread = wdata[MODE_SPREAD_BIT];
               end
               d.mode = wdata[2:0];
               if (wdata[2:0] == MODE_SLEEP) begin
                  for (int i = 0; i < BUF_DEPTH; i++) begin
                     mem_d[i] = 8'h00;
                  end
               end
               if ((wdata[2:0] == MODE_RX_CONT ||
                    wdata[2:0] == MODE_RX_SINGLE) && q.mode != wdata[2:0])
               begin
                  for (int i = 0; i < BUF_DEPTH; i++) begin
                     mem_d[i] = 8'h00;
                  end
                  d.rx_wr = q.rx_base;
                  d.crc_seen = 1'b0;
               end
               if (wdata[2:0] == MODE_TRANSMIT) begin
                  d.tx_rd = q.tx_base;
                  d.tx_left = q.payload;
               end
            end
            ADDR_FREQ_HI: d.freq[23:16] = wdata;
            ADDR_FREQ_MID: d.freq[15:8] = wdata;
            ADDR_FREQ_LO: d.freq[7:0] = wdata;
            ADDR_ACCESS_PTR: d.ptr = wdata;
            ADDR_TX_BASE: d.tx_base = wdata;
            ADDR_RX_BASE: d.rx_base = wdata;
            // A flag set in the same cycle as its clear stays set.
            ADDR_IRQ_FLAGS: d.irq = (q.irq & ~wdata) | (d.irq & ~q.irq);
            ADDR_PAYLOAD_SIZE: d.payload = wdata;
            ADDR_RATE_OFFSET: d.rate_off = wdata;
            default: d.bits = d.bits;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
         q.mode <= MODE_STANDBY;
         q.freq <= FREQ_WORD_RST;
         q.tx_base <= TX_BASE_RST;
         q.rx_base <= RX_BASE_RST;
         q.payload <= PAYLOAD_SIZE_RST;
         for (int i = 0; i < BUF_DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else begin
         q <= d;
         mem_q <= mem_d;
      end
   end

   assign link.miso = q.miso;
   assign link.miso_oe = sel_s;
   assign tx_byte_valid = q.tx_valid;
   assign tx_byte = q.tx_data;
   assign active_mode = q.mode;
   assign carrier_frequency_word = q.freq;
   assign rate_offset_correction = q.rate_off;
   assign rx_crc_error_seen = q.crc_seen;
endmodule

/* pbuf_host.sv */
/*
 * Host end: a classic Wishbone slave that turns each single cycle into a
 * 16-bit serial frame, an address byte (bit 7 = write) then a data byte,
 * and acknowledges with the read data once the frame has ended.
 * Assumes the device answers a read in the second byte of the frame.
 */
`timescale 1ns/100ps
module pbuf_host
   import pbuf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cyc,
   input wire logic stb,
   input wire logic we,
   input wire logic sel,
   input wire logic [pbuf_pkg::ADDR_W-1:0] adr,
   input wire logic [pbuf_pkg::DATA_W-1:0] dat_w,
   output logic ack,
   output logic [pbuf_pkg::DATA_W-1:0] dat_r,
   pbuf_link_if.host link
);
   import pbuf_pkg::*;
   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} hstate_t;
   typedef struct packed {
      hstate_t st;
      logic [3:0] div;
      logic sck;
      logic cs_n;
      logic [4:0] bits;
      logic [15:0] sh;
      logic [7:0] rx;
      logic rsp_valid;
      logic [7:0] rdata;
   } hst_t;
   hst_t q, d;
   logic miso_s;

   pbuf_sync u_miso (.clk(clk), .rst_n(rst_n), .din(link.miso),
      .dout(miso_s));

   always_comb begin
      d = q;
      d.rsp_valid = 1'b0;
      case (q.st)
         H_IDLE: begin
            // No new frame in the acknowledge cycle, while the master still
            // holds its strobe. A write with no lane selected goes as a read.
            if (cyc && stb && !q.rsp_valid) begin
               d.st = H_SHIFT;
               d.cs_n = 1'b0;
               d.sh = {we && sel, adr, dat_w};
               d.bits = 5'h00;
               d.div = HALF_CNT;
            end
         end
         H_SHIFT: begin
            if (q.div == 4'h0) begin
               d.div = HALF_CNT;
               d.sck = !q.sck;
               if (q.sck) begin
                  // Falling edge: present next bit. Read data is taken just
                  // before it, since the round trip through both ends'
                  // synchronisers outlasts the low half of the link clock.
                  d.rx = {q.rx[6:0], miso_s};
                  d.sh = {q.sh[14:0], 1'b0};
                  if (q.bits == FRAME_BITS_5) begin
                     d.st = H_GAP;
                     d.sck = 1'b0;
                  end
               end else begin
                  d.bits = q.bits + 5'h01;
               end
            end else begin
               d.div = q.div - 4'h1;
            end
         end
         H_GAP: begin
            d.cs_n = 1'b1;
            d.st = H_IDLE;
            d.rsp_valid = 1'b1;
            d.rdata = q.rx;
         end
         default: d.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '{st: H_IDLE, div: 4'h0, sck: 1'b0, cs_n: 1'b1,
                bits: 5'h00, sh: 16'h0000, rx: 8'h00, rsp_valid: 1'b0,
                rdata: 8'h00};
      end else begin
         q <= d;
      end
   end

   assign ack = q.rsp_valid;
   assign dat_r = q.rdata;
   assign link.sck = q.sck;
   assign link.cs_n = q.cs_n;
   assign link.mosi = q.sh[15];
endmodule

/* pbuf_link_if.sv */
/*
 * Serial link between the host controller and the radio's register and
 * packet buffer logic. Assumes both ends sample on the same 40 MHz clock.
 */
`timescale 1ns/100ps
interface pbuf_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport device (
      input sck,
      input cs_n,
      input mosi,
      output miso,
      output miso_oe
   );
   modport host (
      output sck,
      output cs_n,
      output mosi,
      input miso,
      input miso_oe
   );
endinterface

/* pbuf_pkg.sv */
/*
 * Shared constants for the packet buffer and mode control block: register
 * addresses, field positions, reset values, mode codes and SPI framing.
 * Assumes a single 40 MHz clock domain on each end of the serial link.
 */
package pbuf_pkg;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BUF_DEPTH = 256;
   localparam int unsigned PTR_W = 8;
   // Register addresses on the serial link.
   localparam logic [6:0] ADDR_DATA_PORT = 7'h00;
   localparam logic [6:0] ADDR_OP_MODE = 7'h01;
   localparam logic [6:0] ADDR_FREQ_HI = 7'h06;
   localparam logic [6:0] ADDR_FREQ_MID = 7'h07;
   localparam logic [6:0] ADDR_FREQ_LO = 7'h08;
   localparam logic [6:0] ADDR_ACCESS_PTR = 7'h0d;
   localparam logic [6:0] ADDR_TX_BASE = 7'h0e;
   localparam logic [6:0] ADDR_RX_BASE = 7'h0f;
   localparam logic [6:0] ADDR_LAST_START = 7'h10;
   localparam logic [6:0] ADDR_IRQ_FLAGS = 7'h12;
   localparam logic [6:0] ADDR_RX_COUNT = 7'h13;
   localparam logic [6:0] ADDR_PAYLOAD_SIZE = 7'h22;
   localparam logic [6:0] ADDR_RATE_OFFSET = 7'h27;
   localparam logic [6:0] ADDR_FEI_HI = 7'h28;
   localparam logic [6:0] ADDR_FEI_MID = 7'h29;
   localparam logic [6:0] ADDR_FEI_LO = 7'h2a;
   // Operating mode and interrupt flag register fields.
   localparam int unsigned MODE_SPREAD_BIT = 7;
   localparam int unsigned IRQ_TX_DONE_BIT = 3;
   localparam int unsigned IRQ_RX_DONE_BIT = 6;
   localparam logic [2:0] MODE_SLEEP = 3'h0;
   localparam logic [2:0] MODE_STANDBY = 3'h1;
   localparam logic [2:0] MODE_SYNTH_TX = 3'h2;
   localparam logic [2:0] MODE_TRANSMIT = 3'h3;
   localparam logic [2:0] MODE_SYNTH_RX = 3'h4;
   localparam logic [2:0] MODE_RX_CONT = 3'h5;
   localparam logic [2:0] MODE_RX_SINGLE = 3'h6;
   localparam logic [2:0] MODE_CAD = 3'h7;
   // Reset values.
   localparam logic [7:0] TX_BASE_RST = 8'h80;
   localparam logic [7:0] RX_BASE_RST = 8'h00;
   localparam logic [7:0] OP_MODE_RST = 8'h01;
   localparam logic [7:0] PAYLOAD_SIZE_RST = 8'h01;
   localparam logic [23:0] FREQ_WORD_RST = 24'h6c_8000;
   // Serial link framing: one address byte then one data byte.
   localparam int unsigned FRAME_BITS = 16;
   localparam logic [4:0] FRAME_BITS_5 = 5'h10;
   // Link clock from the host: 40 MHz / 8 = 5 MHz, half period 4 cycles.
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned LINK_KHZ = 5000;
   localparam int unsigned HALF_CYCLES = CLK_MHZ * 1000 / LINK_KHZ / 2;
   localparam logic [3:0] HALF_CNT = 4'(HALF_CYCLES - 1);
   // Transmit takes two ticks per payload byte in this model; this constant is unused.
   localparam logic [7:0] TX_TICKS_PER_BYTE = 8'h04;
endpackage

/* pbuf_properties.sv */
/*
 * Timing checks on the serial link between the host and device ends.
 * Assumes both ends and this checker share the 40 MHz clock and reset.
 */
`timescale 1ns/100ps
module pbuf_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   logic sck_q;
   logic [4:0] rises_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // The count survives one cycle past the end of a frame for the check.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sck_q <= 1'b0;
         rises_q <= 5'h00;
      end else begin
         sck_q <= sck;
         if (cs_n) begin
            rises_q <= 5'h00;
         end else if (sck && !sck_q) begin
            rises_q <= rises_q + 5'h01;
         end
      end
   end
   a_clock_idle_low: assert property (cs_n |-> !sck)
      else $error("link clock high outside a frame");
   a_first_edge: assert property ($fell(cs_n) |-> !sck[*4] ##1 sck)
      else $error("first link clock edge not four cycles after select");
   a_high_half: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
      else $error("link clock high phase not four cycles");
   a_low_half: assert property ($fell(sck) |-> !sck[*4])
      else $error("link clock low phase shorter than four cycles");
   a_mosi_steady: assert property (sck |-> $stable(mosi))
      else $error("host data changed while link clock high");
   a_miso_steady: assert property (sck && miso_oe |-> $stable(miso))
      else $error("device data changed while link clock high");
   a_sixteen_bits: assert property ($rose(cs_n) |-> rises_q == 5'h10)
      else $error("frame did not carry sixteen bits");
   a_frame_gap: assert property ($rose(cs_n) |=> cs_n)
      else $error("no idle cycle between frames");
   a_drive_select: assert property ($fell(cs_n) |-> ##[1:4] miso_oe)
      else $error("device did not drive its data line when selected");
   a_release_idle: assert property (cs_n [*5] |-> !miso_oe)
      else $error("device drives its data line while deselected");
endmodule

/* pbuf_sync.sv */
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is glitch free relative to the sampling clock.
 */
`timescale 1ns/100ps
module pbuf_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic meta_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

/* tb.sv */
/*
 * Self-checking bench: host and device ends joined over the link.
 * Assumes the request handshake and frame timing of the host end.
 */
`timescale 1ns/100ps
module tb;
   import pbuf_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic sel = 1'b0;
   logic [6:0] adr = 7'h00;
   logic [7:0] dat_w = 8'h00;
   logic ack, tx_byte_valid, rx_crc_error_seen;
   logic [7:0] dat_r, tx_byte, rate_offset_correction;
   logic [2:0] active_mode;
   logic [23:0] carrier_frequency_word;
   logic rx_byte_valid = 1'b0, rx_header_valid = 1'b0;
   logic rx_packet_end = 1'b0, rx_crc_error = 1'b0, tx_byte_ready = 1'b1;
   logic [7:0] rx_byte = 8'h00, rx_header_len = 8'h00, q;
   logic [19:0] freq_error_in = 20'h9_a5c3;
   logic [7:0] txq[$];
   int err_total = 0;
   int comparisons = 0;
   pbuf_link_if link ();
   pbuf_host pbuf_host_i (.clk(clk), .rst_n(rst_n), .cyc(cyc), .stb(stb),
      .we(we), .sel(sel), .adr(adr), .dat_w(dat_w), .ack(ack),
      .dat_r(dat_r), .link(link));
   pbuf_device pbuf_device_i (.clk(clk), .rst_n(rst_n), .link(link),
      .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
      .rx_header_valid(rx_header_valid), .rx_header_len(rx_header_len),
      .rx_packet_end(rx_packet_end), .rx_crc_error(rx_crc_error),
      .freq_error_in(freq_error_in), .tx_byte_ready(tx_byte_ready),
      .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
      .active_mode(active_mode),
      .carrier_frequency_word(carrier_frequency_word),
      .rate_offset_correction(rate_offset_correction),
      .rx_crc_error_seen(rx_crc_error_seen));
   pbuf_properties pbuf_properties_i (.clk(clk), .rst_n(rst_n),
      .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
      .miso(link.miso), .miso_oe(link.miso_oe));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (tx_byte_valid === 1'b1) txq.push_back(tx_byte);
   end
   task automatic chk(input string what, input logic [23:0] exp,
                      input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Classic single cycle: the request stands until the edge that samples
   // ack, which also takes the read data; only the watchdog ends a wait.
   task automatic xfer(input logic w, input logic [6:0] a,
                       input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 1'b1;
      adr <= a;
      dat_w <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk("register read", e, q);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      int n;
      n = 0;
      while (active_mode !== m && n < 600) begin
         @(negedge clk);
         n++;
      end
      chk("active_mode", m, active_mode);
      @(posedge clk);
   endtask
   // Bits are packet end, integrity error, header and byte strobes.
   task automatic rx_in(input logic [3:0] s, input logic [7:0] v);
      {rx_packet_end, rx_crc_error, rx_header_valid, rx_byte_valid} <= s;
      rx_byte <= v;
      rx_header_len <= v;
      @(posedge clk);
      {rx_packet_end, rx_crc_error, rx_header_valid, rx_byte_valid} <= 4'h0;
      @(posedge clk);
   endtask
   task automatic t_reset;
      chk("active_mode", MODE_STANDBY, active_mode);
      chk("frequency", FREQ_WORD_RST, carrier_frequency_word);
      rd(ADDR_TX_BASE, 8'h80);
      rd(ADDR_RX_BASE, 8'h00);
      rd(ADDR_OP_MODE, OP_MODE_RST);
      wr(ADDR_ACCESS_PTR, 8'h05);
      wr(ADDR_DATA_PORT, 8'h3c);
      wr(ADDR_ACCESS_PTR, 8'h05);
      rd(ADDR_DATA_PORT, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_modes;
      logic [2:0] m[3] = '{MODE_SYNTH_TX, MODE_SYNTH_RX, MODE_CAD};
      wr(ADDR_OP_MODE, 8'h00);
      wr(ADDR_OP_MODE, 8'h80);
      wait_mode(MODE_SLEEP);
      rd(ADDR_OP_MODE, 8'h80);
      rd(ADDR_TX_BASE, 8'h80);
      rd(ADDR_DATA_PORT, 8'h00);
      foreach (m[i]) begin
         wr(ADDR_OP_MODE, {5'h10, m[i]});
         wait_mode(m[i]);
      end
      wr(ADDR_OP_MODE, 8'h81);
      wait_mode(MODE_STANDBY);
      wr(ADDR_OP_MODE, 8'h01);
      rd(ADDR_OP_MODE, 8'h81);
      $display("test modes done");
   endtask
   task automatic t_buffer;
      wr(ADDR_TX_BASE, 8'h10);
      wr(ADDR_RX_BASE, 8'hfe);
      rd(ADDR_TX_BASE, 8'h10);
      rd(ADDR_RX_BASE, 8'hfe);
      wr(ADDR_ACCESS_PTR, 8'hfe);
      for (int i = 0; i < 4; i++) wr(ADDR_DATA_PORT, 8'ha0 + 8'(i));
      rd(ADDR_ACCESS_PTR, 8'h02);
      wr(ADDR_ACCESS_PTR, 8'hfe);
      for (int i = 0; i < 4; i++) rd(ADDR_DATA_PORT, 8'ha0 + 8'(i));
      $display("test buffer done");
   endtask
   task automatic t_tx;
      int n;
      n = 0;
      wr(ADDR_ACCESS_PTR, 8'h10);
      for (int i = 0; i < 3; i++) wr(ADDR_DATA_PORT, 8'h51 + 8'(i));
      wr(ADDR_PAYLOAD_SIZE, 8'h03);
      txq.delete();
      wr(ADDR_OP_MODE, {5'h10, MODE_TRANSMIT});
      while (txq.size() < 3 && n < 600) begin
         @(negedge clk);
         n++;
      end
      chk("sent bytes", 24'h3, 24'(txq.size()));
      foreach (txq[i]) chk("sent byte", 8'h51 + 8'(i), txq[i]);
      wait_mode(MODE_STANDBY);
      rd(ADDR_IRQ_FLAGS, 8'h08);
      wr(ADDR_IRQ_FLAGS, 8'h08);
      wr(ADDR_ACCESS_PTR, 8'h10);
      rd(ADDR_DATA_PORT, 8'h51);
      $display("test transmit done");
   endtask
   task automatic t_rx_single;
      wr(ADDR_OP_MODE, {5'h10, MODE_RX_SINGLE});
      wait_mode(MODE_RX_SINGLE);
      rx_in(4'h2, 8'h03);
      rx_in(4'h1, 8'hc1);
      rx_in(4'h4, 8'h00);
      rx_in(4'h1, 8'hc2);
      rx_in(4'h1, 8'hc3);
      rx_in(4'h8, 8'h00);
      wait_mode(MODE_STANDBY);
      chk("integrity error", 1'b1, rx_crc_error_seen);
      rd(ADDR_RX_COUNT, 8'h03);
      rd(ADDR_LAST_START, 8'hfe);
      rd(ADDR_FEI_HI, 8'h09);
      rd(ADDR_FEI_MID, 8'ha5);
      rd(ADDR_FEI_LO, 8'hc3);
      wr(ADDR_ACCESS_PTR, 8'hfe);
      for (int i = 0; i < 3; i++) rd(ADDR_DATA_PORT, 8'hc1 + 8'(i));
      wr(ADDR_ACCESS_PTR, 8'h10);
      rd(ADDR_DATA_PORT, 8'h00);
      $display("test single receive done");
   endtask
   task automatic t_rx_cont;
      wr(ADDR_RX_BASE, 8'h7f);
      wr(ADDR_OP_MODE, {5'h10, MODE_RX_CONT});
      wait_mode(MODE_RX_CONT);
      rx_in(4'h2, 8'h02);
      rx_in(4'h1, 8'hd1);
      rx_in(4'h1, 8'hd2);
      rx_in(4'h8, 8'h00);
      repeat (20) @(posedge clk);
      chk("active_mode", MODE_RX_CONT, active_mode);
      wr(ADDR_OP_MODE, 8'h81);
      wait_mode(MODE_STANDBY);
      wr(ADDR_ACCESS_PTR, 8'h80);
      rd(ADDR_DATA_PORT, 8'hd2);
      wr(ADDR_OP_MODE, 8'h80);
      wait_mode(MODE_SLEEP);
      wr(ADDR_OP_MODE, 8'h81);
      wait_mode(MODE_STANDBY);
      wr(ADDR_ACCESS_PTR, 8'h80);
      rd(ADDR_DATA_PORT, 8'h00);
      $display("test continuous receive done");
   endtask
   task automatic t_freq;
      wr(ADDR_FREQ_HI, 8'hd9);
      wr(ADDR_FREQ_MID, 8'h06);
      wr(ADDR_FREQ_LO, 8'h66);
      rd(ADDR_FREQ_LO, 8'h66);
      chk("frequency", 24'hd9_0666, carrier_frequency_word);
      wr(ADDR_RATE_OFFSET, 8'hf3);
      rd(ADDR_RATE_OFFSET, 8'hf3);
      chk("rate offset", 8'hf3, rate_offset_correction);
      $display("test frequency done");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset;
      t_modes;
      t_buffer;
      t_tx;
      t_rx_single;
      t_rx_cont;
      t_freq;
      results;
   end
   // About 70 frames of some 135 cycles each, with a wide margin.
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      $display("[ERR] run expected finish seen timeout");
      results;
   end
endmodule
